// >>> hdl/orcd_pkg.sv
// orcd_pkg: opcodes, field values, reset values and types of the octal command decoder
package orcd_pkg;

   // ****************************************************************
   // opcode pairs, first byte then second byte
   // ****************************************************************
   localparam logic [7:0] OP_NOP_1    = 8'h00;
   localparam logic [7:0] OP_NOP_2    = 8'hFF;
   localparam logic [7:0] OP_ARM_1    = 8'h66;
   localparam logic [7:0] OP_ARM_2    = 8'h99;
   localparam logic [7:0] OP_EXEC_1   = 8'h99;
   localparam logic [7:0] OP_EXEC_2   = 8'h66;
   localparam logic [7:0] OP_SR_RD_1  = 8'h05;
   localparam logic [7:0] OP_SR_RD_2  = 8'hFA;
   localparam logic [7:0] OP_CR_RD_1  = 8'h15;
   localparam logic [7:0] OP_CR_RD_2  = 8'hEA;
   localparam logic [7:0] OP_CR2_RD_1 = 8'h71;
   localparam logic [7:0] OP_CR2_RD_2 = 8'h8E;
   localparam logic [7:0] OP_FB_RD_1  = 8'h16;
   localparam logic [7:0] OP_FB_RD_2  = 8'hE9;
   localparam logic [7:0] OP_SC_RD_1  = 8'h2B;
   localparam logic [7:0] OP_SC_RD_2  = 8'hD4;
   localparam logic [7:0] OP_LK_RD_1  = 8'h2D;
   localparam logic [7:0] OP_LK_RD_2  = 8'hD2;
   localparam logic [7:0] OP_WR_1     = 8'h01;
   localparam logic [7:0] OP_WR_2     = 8'hFE;

   // ****************************************************************
   // phase lengths and fixed bytes
   // ****************************************************************
   localparam logic [2:0] ADDR_LAST   = 3'h3;    // four address bytes, index 0..3
   localparam logic [2:0] DUMMY_LAST  = 3'h3;    // four dummy cycles, index 0..3
   localparam logic [7:0] SEL_STATUS  = 8'h00;
   localparam logic [7:0] SEL_CONFIG  = 8'h01;

   // ****************************************************************
   // register values after reset
   // ****************************************************************
   localparam logic [7:0]  RST_STATUS  = 8'h00;
   localparam logic [7:0]  RST_CONFIG  = 8'h00;
   localparam logic [7:0]  RST_CONFIG2 = 8'h00;
   localparam logic [31:0] RST_FBOOT   = 32'h0000_0000;
   localparam logic [7:0]  RST_SECUR   = 8'h00;
   localparam logic [7:0]  RST_LOCK    = 8'h00;

   typedef enum logic [2:0] {
      ST_OP1   = 3'b000,
      ST_OP2   = 3'b001,
      ST_ADDR  = 3'b010,
      ST_DUMMY = 3'b011,
      ST_WDATA = 3'b100,
      ST_RDATA = 3'b101,
      ST_SKIP  = 3'b110
   } orcd_state_t;

   typedef enum logic [2:0] {
      K_NONE   = 3'b000,
      K_SR_RD  = 3'b001,
      K_CR_RD  = 3'b010,
      K_CR2_RD = 3'b011,
      K_FB_RD  = 3'b100,
      K_SC_RD  = 3'b101,
      K_LK_RD  = 3'b110,
      K_WR     = 3'b111
   } orcd_kind_t;

endpackage

// >>> hdl/orcd_xfer_if.sv
// orcd_xfer_if: link-domain to system-domain carrier of register writes and reset events
`timescale 1ns/100ps
interface orcd_xfer_if;
   logic       wr_tgl;      // flips once per completed register write
   logic [7:0] status_val;  // stable between toggles
   logic [7:0] config_val;  // stable between toggles
   logic       rst_tgl;     // flips once per honoured reset execute

   modport link (output wr_tgl, output status_val, output config_val, output rst_tgl);
   modport sys  (input wr_tgl, input status_val, input config_val, input rst_tgl);
endinterface

// >>> hdl/orcd_sys_sync.sv
// orcd_sys_sync: system-clock receiver of the toggle crossings from the link domain
`timescale 1ns/100ps
module orcd_sys_sync
   import orcd_pkg::*;
(
   input  wire logic  clk_i,         // system clock
   input  wire logic  nrst_i,        // async reset, active low
   orcd_xfer_if.sys   xf,            // link-side toggles and words
   output logic [7:0] status_o,      // mirrored status register
   output logic [7:0] config_o,      // mirrored configuration register
   output logic       reset_exec_o   // one-cycle pulse per honoured reset execute
);

   logic [2:0] wr_sync;
   logic [2:0] rst_sync;

   // ****************************************************************
   // toggle synchronisers; stage 0 is read only by stage 1
   // ****************************************************************
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_sync  <= 3'h0;
         rst_sync <= 3'h0;
      end else begin
         wr_sync  <= {wr_sync[1:0], xf.wr_tgl};
         rst_sync <= {rst_sync[1:0], xf.rst_tgl};
      end
   end

   // words change on the same link edge as their toggle and hold while it crosses, so they are safe to take here
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         status_o <= RST_STATUS;
         config_o <= RST_CONFIG;
      end else if (wr_sync[2] != wr_sync[1]) begin
         status_o <= xf.status_val;
         config_o <= xf.config_val;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reset_exec_o <= 1'b0;
      end else begin
         reset_exec_o <= rst_sync[2] != rst_sync[1];
      end
   end

endmodule

// >>> hdl/orcd_top.sv
// orcd_top: octal-mode reset and register command decoder of the serial flash
// Functional notes
// [R1] reset group pairs carry no further bytes
// [R2] register reads: pair, four bytes, dummy, data
// [R3] status write 01/FE, fixed 00h, loads byte
// [R4] fourth fixed byte 01h selects configuration register
// [R5] reset execute only right after reset arm
// [R6] read dummy phase is four cycles always
// [R7] fast-boot read data always single-edge rate
// [R8] host sends second opcode as complement of first
`timescale 1ns/100ps
module orcd_top
   import orcd_pkg::*;
#(
   parameter logic [7:0]  CONFIG2_VAL = RST_CONFIG2,   // content of configuration register 2
   parameter logic [31:0] FBOOT_VAL   = RST_FBOOT,     // content of fast-boot register
   parameter logic [7:0]  SECUR_VAL   = RST_SECUR,     // content of security register
   parameter logic [7:0]  LOCK_VAL    = RST_LOCK       // content of lock register
)(
   input  wire logic       clk_i,          // system clock, 40 MHz
   input  wire logic       nrst_i,         // async reset, active low
   input  wire logic       sck_i,          // link serial clock from host
   input  wire logic       cs_n_i,         // chip select, active low
   input  wire logic [7:0] dq_i,           // octal data lines, input side
   output logic      [7:0] dq_o,           // octal data lines, output side
   output logic            dq_oe_o,        // high while device drives dq
   output logic      [7:0] status_o,       // status register, system domain
   output logic      [7:0] config_o,       // configuration register, system domain
   output logic            reset_exec_o    // pulse when reset execute is honoured
);

   orcd_xfer_if xf ();

   orcd_state_t state;
   orcd_kind_t  kind;
   logic [7:0]  op1;
   logic [2:0]  cnt;
   logic [1:0]  ptr;
   logic        sel_cfg;
   logic        armed;
   logic [7:0]  status_reg;
   logic [7:0]  config_reg;
   logic        wr_tgl;
   logic        rst_tgl;
   logic [7:0]  out_byte;
   logic        out_en;
   logic        is_arm;
   logic        is_exec;
   logic        is_nop;
   orcd_kind_t  next_kind;

   // ****************************************************************
   // opcode pair decoding
   // ****************************************************************
   function automatic orcd_kind_t pair_kind(input logic [7:0] a, input logic [7:0] b);
      orcd_kind_t k;
      k = K_NONE;
      if      (a == OP_SR_RD_1  && b == OP_SR_RD_2)  k = K_SR_RD;
      else if (a == OP_CR_RD_1  && b == OP_CR_RD_2)  k = K_CR_RD;
      else if (a == OP_CR2_RD_1 && b == OP_CR2_RD_2) k = K_CR2_RD;
      else if (a == OP_FB_RD_1  && b == OP_FB_RD_2)  k = K_FB_RD;
      else if (a == OP_SC_RD_1  && b == OP_SC_RD_2)  k = K_SC_RD;
      else if (a == OP_LK_RD_1  && b == OP_LK_RD_2)  k = K_LK_RD;
      else if (a == OP_WR_1     && b == OP_WR_2)     k = K_WR;
      return k;
   endfunction

   function automatic logic [1:0] last_ptr(input orcd_kind_t k);
      return (k == K_FB_RD) ? 2'h3 : 2'h0;
   endfunction

   // full pairs are matched, so a pair whose second byte is not the complement is dropped
   assign next_kind = pair_kind(op1, dq_i);                       // see [R8]
   assign is_nop    = (op1 == OP_NOP_1)  && (dq_i == OP_NOP_2);
   assign is_arm    = (op1 == OP_ARM_1)  && (dq_i == OP_ARM_2);
   assign is_exec   = (op1 == OP_EXEC_1) && (dq_i == OP_EXEC_2);

   // ****************************************************************
   // frame sequencer; chip select high ends the frame without an edge
   // ****************************************************************
   always_ff @(posedge sck_i or posedge cs_n_i or negedge nrst_i) begin
      if (!nrst_i || cs_n_i) begin
         state   <= ST_OP1;
         kind    <= K_NONE;
         op1     <= 8'h00;
         cnt     <= 3'h0;
         ptr     <= 2'h0;
         sel_cfg <= 1'b0;
      end else begin
         case (state)
            ST_OP1: begin
               op1   <= dq_i;
               state <= ST_OP2;
            end
            ST_OP2: begin
               kind <= next_kind;
               cnt  <= 3'h0;
               // reset group and unknown pairs take no more bytes
               state <= (next_kind == K_NONE) ? ST_SKIP : ST_ADDR;   // see [R1] [R2]
            end
            ST_ADDR: begin
               cnt <= 3'(cnt + 3'h1);
               if (cnt == ADDR_LAST) begin
                  cnt <= 3'h0;
                  if (kind == K_WR) begin
                     sel_cfg <= (dq_i == SEL_CONFIG);              // see [R3] [R4]
                     state   <= (dq_i == SEL_CONFIG || dq_i == SEL_STATUS) ? ST_WDATA : ST_SKIP;
                  end else if (kind == K_CR_RD && dq_i != SEL_CONFIG) begin
                     state <= ST_SKIP;                             // see [R4]
                  end else begin
                     state <= ST_DUMMY;                            // see [R2]
                  end
               end
            end
            ST_DUMMY: begin
               // counted in clock cycles, the same in both transfer rates
               cnt <= 3'(cnt + 3'h1);
               if (cnt == DUMMY_LAST) begin                        // see [R6]
                  state <= ST_RDATA;
                  ptr   <= 2'h0;
               end
            end
            ST_RDATA: begin
               // one byte per cycle, also for fast-boot on a double-edge link
               ptr <= (ptr == last_ptr(kind)) ? 2'h0 : 2'(ptr + 2'h1);   // see [R7]
            end
            ST_WDATA: begin
               state <= ST_SKIP;
            end
            ST_SKIP: begin
               state <= ST_SKIP;
            end
            default: begin
               state <= ST_SKIP;
            end
         endcase
      end
   end

   // ****************************************************************
   // reset arm / execute; arm survives the frame boundary
   // ****************************************************************
   always_ff @(posedge sck_i or negedge nrst_i) begin
      if (!nrst_i) begin
         armed <= 1'b0;
      end else if (!cs_n_i && state == ST_OP2) begin
         // any completed pair other than arm disarms, including no-operation
         armed <= is_arm;                                          // see [R5]
      end
   end

   always_ff @(posedge sck_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_tgl <= 1'b0;
      end else if (!cs_n_i && state == ST_OP2 && is_exec && armed) begin
         rst_tgl <= ~rst_tgl;                                      // see [R5]
      end
   end

   // ****************************************************************
   // writable registers
   // ****************************************************************
   always_ff @(posedge sck_i or negedge nrst_i) begin
      if (!nrst_i) begin
         status_reg <= RST_STATUS;
         config_reg <= RST_CONFIG;
         wr_tgl     <= 1'b0;
      end else if (!cs_n_i && state == ST_WDATA) begin
         if (sel_cfg) begin
            config_reg <= dq_i;                                    // see [R4]
         end else begin
            status_reg <= dq_i;                                    // see [R3]
         end
         wr_tgl <= ~wr_tgl;
      end
   end

   // ****************************************************************
   // read data; launched on the falling edge so the host samples mid-bit
   // ****************************************************************
   function automatic logic [7:0] read_byte(input orcd_kind_t k, input logic [1:0] p,
                                            input logic [7:0] sr, input logic [7:0] cr);
      logic [7:0] v;
      v = 8'h00;
      case (k)
         K_SR_RD:  v = sr;
         K_CR_RD:  v = cr;
         K_CR2_RD: v = CONFIG2_VAL;
         K_FB_RD:  v = FBOOT_VAL[8*p +: 8];
         K_SC_RD:  v = SECUR_VAL;
         K_LK_RD:  v = LOCK_VAL;
         default:  v = 8'h00;
      endcase
      return v;
   endfunction

   always_ff @(negedge sck_i or posedge cs_n_i or negedge nrst_i) begin
      if (!nrst_i || cs_n_i) begin
         out_byte <= 8'h00;
         out_en   <= 1'b0;
      end else begin
         out_byte <= read_byte(kind, ptr, status_reg, config_reg);
         out_en   <= (state == ST_RDATA);                          // see [R2]
      end
   end

   assign dq_o    = out_byte;
   assign dq_oe_o = out_en;

   assign xf.wr_tgl     = wr_tgl;
   assign xf.status_val = status_reg;
   assign xf.config_val = config_reg;
   assign xf.rst_tgl    = rst_tgl;

   orcd_sys_sync u_sync (
      .clk_i        (clk_i),
      .nrst_i       (nrst_i),
      .xf           (xf),
      .status_o     (status_o),
      .config_o     (config_o),
      .reset_exec_o (reset_exec_o)
   );

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence s_dummy_run;
      (state == ST_DUMMY)[*4] ##1 (state == ST_RDATA);
   endsequence

   AST_RESET_GROUP_ENDS: assert property (@(posedge sck_i) disable iff (!nrst_i || cs_n_i) // see [R1]
      (state == ST_OP2 && (is_nop || is_arm || is_exec)) |=> (state == ST_SKIP))
      else $error("reset group pair did not end the command");

   AST_READ_TO_ADDR: assert property (@(posedge sck_i) disable iff (!nrst_i || cs_n_i) // see [R2]
      (state == ST_OP2 && next_kind != K_NONE && next_kind != K_WR) |=> (state == ST_ADDR) [*4])
      else $error("read pair did not take four address bytes");

   AST_STATUS_LOAD: assert property (@(posedge sck_i) disable iff (!nrst_i || cs_n_i) // see [R3]
      (state == ST_WDATA && !sel_cfg) |=>
         (status_reg == $past(dq_i) && config_reg == $past(config_reg)))
      else $error("status write did not load the data byte");

   AST_CONFIG_LOAD: assert property (@(posedge sck_i) disable iff (!nrst_i || cs_n_i) // see [R4]
      (state == ST_WDATA && sel_cfg) |=>
         (config_reg == $past(dq_i) && status_reg == $past(status_reg)))
      else $error("configuration write did not load the data byte");

   AST_EXEC_UNARMED: assert property (@(posedge sck_i) disable iff (!nrst_i || cs_n_i) // see [R5]
      (state == ST_OP2 && is_exec && !armed) |=> $stable(rst_tgl))
      else $error("reset execute honoured without arm");

   AST_EXEC_ARMED: assert property (@(posedge sck_i) disable iff (!nrst_i || cs_n_i) // see [R5]
      (state == ST_OP2 && is_exec && armed) |=> (rst_tgl != $past(rst_tgl) && !armed))
      else $error("armed reset execute not honoured");

   AST_DUMMY_FOUR: assert property (@(posedge sck_i) disable iff (!nrst_i || cs_n_i) // see [R6]
      (state == ST_DUMMY && $past(state) == ST_ADDR) |-> s_dummy_run)
      else $error("dummy phase not four cycles");

   AST_FBOOT_RATE: assert property (@(posedge sck_i) disable iff (!nrst_i || cs_n_i) // see [R7]
      (state == ST_RDATA && kind == K_FB_RD) |=> (ptr == 2'($past(ptr) + 2'h1)))
      else $error("fast-boot byte pointer not one per cycle");

endmodule

// >>> test/orcd_host_model.sv
// orcd_host_model: behavioural octal host controller that frames commands into the decoder
`timescale 1ns/100ps
module orcd_host_model (
   output logic            sck_o,    // serial clock, runs only inside frames
   output logic            cs_n_o,   // chip select, active low
   output logic      [7:0] dq_o,     // octal lines towards the device
   input  wire logic [7:0] dq_i,     // octal lines from the device
   input  wire logic       oe_i      // device drive enable
);
   // ****************************************************************
   // idle state: clock parked low, device deselected
   // ****************************************************************
   initial begin
      sck_o  = 1'b0;
      cs_n_o = 1'b1;
      dq_o   = 8'h00;
   end

   // ****************************************************************
   // one frame; ncyc 3 = reset group, 8 = write, 10+n = read of n bytes
   // one trailing byte on short frames so the device's follow-up checks see a clock
   // ****************************************************************
   task automatic frame(input logic [7:0] op1, input logic bad, input logic [7:0] sel,
                        input logic [7:0] wd, input int ncyc, output logic [7:0] rd [4],
                        output logic [15:0] oe_seen, output logic edge_ok);
      int i;
      edge_ok = 1'b1;
      oe_seen = '0;
      rd      = '{default: 8'h00};
      cs_n_o  = 1'b0;
      #8;
      for (i = 0; i < ncyc; i++) begin
         if (i == 0)
            dq_o = op1;
         else if (i == 1)
            dq_o = bad ? op1 : ~op1;
         else if (i < 5)
            dq_o = 8'h00;
         else if (i == 5)
            dq_o = sel;
         else if (i == 6 && ncyc == 8)
            dq_o = wd;
         else
            dq_o = ~dq_o;                       // stale values must not look valid
         #8 sck_o = 1'b1;
         oe_seen[i] = oe_i;
         if (i >= 10)
            rd[i-10] = dq_i;
         #8;
         if (i >= 10 && dq_i !== rd[i-10])
            edge_ok = 1'b0;
         #8 sck_o = 1'b0;
         #8;
      end
      cs_n_o = 1'b1;
      dq_o   = ~dq_o;
   endtask
endmodule

// >>> test/tb_top.sv
// tb_top: self-checking testbench of the octal reset and register command decoder
`timescale 1ns/100ps
module tb_top
   import orcd_pkg::*;
;
   localparam logic [7:0]  C2 = 8'h5A;
   localparam logic [31:0] FB = 32'hC3B2_A190;
   localparam logic [7:0]  SC = 8'h96;
   localparam logic [7:0]  LK = 8'hC7;

   logic        clk_i;
   logic        nrst_i;
   logic        sck;
   logic        cs_n;
   logic [7:0]  dq_h2d;
   logic [7:0]  dq_d2h;
   logic        dq_oe;
   logic [7:0]  status;
   logic [7:0]  config_r;
   logic        rexec;
   logic [7:0]  rd [4];
   logic [15:0] oe;
   logic        eok;
   logic [7:0]  n_pulse;
   int          n_errors;
   int          tests_run;
   int          cyc;

   // ****************************************************************
   // design and host
   // ****************************************************************
   orcd_top #(.CONFIG2_VAL(C2), .FBOOT_VAL(FB), .SECUR_VAL(SC), .LOCK_VAL(LK)) uut (
      .clk_i(clk_i), .nrst_i(nrst_i), .sck_i(sck), .cs_n_i(cs_n), .dq_i(dq_h2d),
      .dq_o(dq_d2h), .dq_oe_o(dq_oe), .status_o(status), .config_o(config_r),
      .reset_exec_o(rexec));
   orcd_host_model host (.sck_o(sck), .cs_n_o(cs_n), .dq_o(dq_h2d), .dq_i(dq_d2h),
      .oe_i(dq_oe));

   initial clk_i = 1'b0;
   always #12.5 clk_i = ~clk_i;

   // ****************************************************************
   // bookkeeping, pulse counter and hang guard
   // ****************************************************************
   task automatic test_done();
      $display("Counts: %0d mismatches in %0d checks", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // counted on the falling edge, clear of the edge that launches the pulse
   always @(negedge clk_i) begin
      cyc++;
      if (rexec === 1'b1)
         n_pulse++;
      if (cyc == 5000) begin
         n_errors++;
         test_done();
      end
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   // frame plus enough idle time for the mirror to settle in the system domain
   task automatic run(input logic [7:0] op1, input logic bad, input logic [7:0] sel,
                      input logic [7:0] wd, input int ncyc);
      host.frame(op1, bad, sel, wd, ncyc, rd, oe, eok);
      repeat (10) @(negedge clk_i);
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_writes();
      chk8(status, RST_STATUS, "status after reset");
      chk8(config_r, RST_CONFIG, "config after reset");
      chk1(dq_oe, 1'b0, "drive enable after reset");
      run(OP_WR_1, 1'b0, SEL_STATUS, 8'hA5, 8);
      chk8(status, 8'hA5, "status write");
      chk8(config_r, 8'h00, "config kept on status write");
      run(OP_WR_1, 1'b0, SEL_CONFIG, 8'h3C, 8);
      chk8(config_r, 8'h3C, "config write");
      chk8(status, 8'hA5, "status kept on config write");
   endtask

   task automatic t_reads();
      logic [7:0] ops [5];
      logic [7:0] sels [5];
      logic [7:0] exps [5];
      int k;
      ops  = '{OP_SR_RD_1, OP_CR_RD_1, OP_CR2_RD_1, OP_SC_RD_1, OP_LK_RD_1};
      sels = '{SEL_STATUS, SEL_CONFIG, 8'h00, 8'h00, 8'h00};
      exps = '{8'hA5, 8'h3C, C2, SC, LK};
      for (k = 0; k < 5; k++) begin
         run(ops[k], 1'b0, sels[k], 8'h00, 12);
         chk1(oe[9], 1'b0, "no drive in last dummy");
         chk1(oe[10], 1'b1, "drive in first data");
         chk8(rd[0], exps[k], "read byte 0");
         chk8(rd[1], exps[k], "read byte 1");
      end
      run(OP_FB_RD_1, 1'b0, 8'h00, 8'h00, 14);
      for (k = 0; k < 4; k++)
         chk8(rd[k], FB[8*k +: 8], "fast boot byte");
      chk1(eok, 1'b1, "fast boot byte held over cycle");
   endtask

   task automatic t_reset_cmds();
      logic [7:0] p0;
      p0 = n_pulse;
      run(OP_ARM_1, 1'b0, 8'h00, 8'h00, 3);
      run(OP_EXEC_1, 1'b0, 8'h00, 8'h00, 3);
      chk8(n_pulse - p0, 8'h01, "armed execute");
      run(OP_EXEC_1, 1'b0, 8'h00, 8'h00, 3);
      chk8(n_pulse - p0, 8'h01, "repeated execute");
      run(OP_ARM_1, 1'b0, 8'h00, 8'h00, 3);
      run(OP_NOP_1, 1'b0, 8'h00, 8'h00, 3);
      run(OP_EXEC_1, 1'b0, 8'h00, 8'h00, 3);
      chk8(n_pulse - p0, 8'h01, "execute after other");
      chk8(status, 8'hA5, "status kept by reset group");
   endtask

   task automatic t_refused();
      run(OP_WR_1, 1'b1, SEL_STATUS, 8'h11, 8);
      chk8(status, 8'hA5, "bad second opcode");
      run(OP_WR_1, 1'b0, 8'h02, 8'h22, 8);
      chk8(status, 8'hA5, "bad selector status");
      chk8(config_r, 8'h3C, "bad selector config");
      run(OP_CR_RD_1, 1'b0, 8'h00, 8'h00, 12);
      chk1(oe[10], 1'b0, "config read wrong selector");
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      nrst_i    = 1'b0;
      n_errors  = 0;
      tests_run = 0;
      cyc       = 0;
      n_pulse   = 8'h00;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i) nrst_i = 1'b1;
      repeat (4) @(negedge clk_i);
      t_writes();
      t_reads();
      t_reset_cmds();
      t_refused();
      test_done();
   end
endmodule
